/* File: logic/dmc_defines.vh */
// Constants for the single DMA channel: register indices, descriptor
// layout, field positions and reset values.
// Assumes inclusion by bare name from each design file.
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define DMC_IDX_DESC_BASE 8'h10
`define DMC_IDX_WB_BASE 8'h11
`define DMC_IDX_CTRL 8'h12
`define DMC_IDX_CMD 8'h13
`define DMC_IDX_COUNT 8'h14
`define DMC_IDX_IEN_CLR 8'h4C
`define DMC_IDX_IEN_SET 8'h4D
`define DMC_IDX_FLAGS 8'h4E
`define DMC_IDX_STATE 8'h4F
`define DMC_RST_BYTE 8'h00

// ----------------------------------------
// Descriptor layout in system memory
// ----------------------------------------
`define DMC_SLOT_BYTES 32'h0000_0010
`define DMC_DOFS_CTRL 32'h0000_0000
`define DMC_DOFS_CNT 32'h0000_0002
`define DMC_DOFS_SRC 32'h0000_0004
`define DMC_DOFS_DST 32'h0000_0008
`define DMC_DOFS_LINK 32'h0000_000C

// ----------------------------------------
// Block control word fields
// ----------------------------------------
`define DMC_F_VALID 0
`define DMC_F_EVO_LO 1
`define DMC_F_ACT_LO 3
`define DMC_F_BEAT_LO 8
`define DMC_F_SRC_ADV 10
`define DMC_F_DST_ADV 11
`define DMC_F_STEP_TGT 12
`define DMC_F_STEP_LO 13
`define DMC_EVO_BLOCK 2'h1
`define DMC_EVO_BEAT 2'h3
`define DMC_SIZE_WORD 2'h2

// ----------------------------------------
// Flag, status, command bits
// ----------------------------------------
`define DMC_B_ERR 0
`define DMC_B_DONE 1
`define DMC_B_HALT 2
`define DMC_B_WAIT 0
`define DMC_B_BUSY 1
`define DMC_B_FAULT 2
`define DMC_C_HALT 0
`define DMC_C_RESUME 1
`define DMC_C_TRIG 2

`endif

/* File: logic/dmc_flag_reg.v */
// Sticky flag bank: hardware set pulses, software write-one clears.
// Assumes set and clear vectors synchronous to hclk.
`timescale 1ns/100ps
`default_nettype none
module dmc_flag_reg #(
	parameter W = 3
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Set and clear strobes
	input wire [W-1:0] set,
	input wire [W-1:0] clr,
	// Flag state
	output reg [W-1:0] q_ff
);

// ----------------------------------------
// Flag storage
// ----------------------------------------
// Set wins over a clear in the same cycle so no event is lost
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		q_ff <= {W{1'b0}};
	end else begin
		q_ff <= (q_ff & ~clr) | set;
	end
end

endmodule
`default_nettype wire

/* File: logic/dmc_addr_gen.v */
// Beat stride and first-beat address from a loaded descriptor.
// Assumes descriptor fields are stable while its outputs are used.
`timescale 1ns/100ps
`default_nettype none
`include "dmc_defines.vh"
module dmc_addr_gen (
	// Descriptor fields
	input wire [15:0] ctrl,
	input wire [15:0] cnt,
	input wire [31:0] src_end,
	input wire [31:0] dst_end,
	// Derived addresses
	output wire [31:0] src_stride,
	output wire [31:0] dst_stride,
	output wire [31:0] src_first,
	output wire [31:0] dst_first
);

// ----------------------------------------
// Stride per beat
// ----------------------------------------
// Reserved width code 3 gives 8 bytes; software must avoid it
wire [31:0] beat_bytes = 32'h0000_0001 << ctrl[`DMC_F_BEAT_LO+1:`DMC_F_BEAT_LO];
wire [31:0] step_bytes = beat_bytes << ctrl[`DMC_F_STEP_LO+2:`DMC_F_STEP_LO];
wire sel_src = ctrl[`DMC_F_STEP_TGT];

// Step applies to only one side
assign src_stride = !ctrl[`DMC_F_SRC_ADV] ? 32'h0000_0000 :
	(sel_src ? step_bytes : beat_bytes);
assign dst_stride = !ctrl[`DMC_F_DST_ADV] ? 32'h0000_0000 :
	(sel_src ? beat_bytes : step_bytes);

// ----------------------------------------
// Walk back from the last-beat address
// ----------------------------------------
wire [15:0] span = (cnt == 16'h0000) ? 16'h0000 : cnt - 16'h0001;
wire [31:0] span32 = {16'h0000, span};
assign src_first = src_end - span32 * src_stride;
assign dst_first = dst_end - span32 * dst_stride;

endmodule
`default_nettype wire

/* File: logic/dmc_channel.v */
// One DMA channel: AHB-Lite register slave, descriptor fetch, beat mover,
// write-back of the counter, flags, status and interrupt request.
// Assumes system memory answers each mem_req with a one-cycle mem_ack.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dmc_defines.vh"
module dmc_channel #(
	parameter CH_NUM = 0
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	// System memory master port
	output reg mem_req,
	output reg [31:0] mem_addr,
	output reg mem_write,
	output reg [1:0] mem_size,
	output reg [31:0] mem_wdata,
	input wire mem_ack,
	input wire mem_err,
	input wire [31:0] mem_rdata,
	// Triggers and events
	input wire trig_in,
	input wire halt_evt_in,
	output reg evt_out,
	output reg irq
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_FETCH = 3'h1;
localparam [2:0] S_CALC = 3'h2;
localparam [2:0] S_RD = 3'h3;
localparam [2:0] S_WR = 3'h4;
localparam [2:0] S_END = 3'h5;
localparam [2:0] S_WBI = 3'h6;
localparam [2:0] S_WB = 3'h7;
localparam [31:0] SLOT_OFS = CH_NUM * `DMC_SLOT_BYTES;

// ----------------------------------------
// Declarations
// ----------------------------------------
reg [2:0] state_ff;
reg [1:0] widx_ff;
reg ph_wr_ff;
reg ph_hit_ff;
reg [7:0] ph_idx_ff;
reg [31:0] desc_base_ff;
reg [31:0] wb_base_ff;
reg enable_ff;
reg [2:0] ien_ff;
reg fault_ff;
reg busy_ff;
reg wait_ff;
reg halted_ff;
reg halt_req_ff;
reg blk_active_ff;
reg wb_clrv_ff;
reg [31:0] fetch_addr_ff;
reg [15:0] ctrl_ff;
reg [15:0] cnt_ff;
reg [31:0] src_end_ff;
reg [31:0] dst_end_ff;
reg [31:0] link_ff;
reg [31:0] src_ff;
reg [31:0] dst_ff;
reg [31:0] data_ff;
reg ev_err_ff;
reg ev_done_ff;
reg ev_halt_ff;
reg [31:0] nxt_rdata;
wire [2:0] flags;
wire [31:0] src_stride;
wire [31:0] dst_stride;
wire [31:0] src_first;
wire [31:0] dst_first;

// ----------------------------------------
// Bus decode
// ----------------------------------------
wire ap_take = hsel & hready & htrans[1];
wire ap_hit = (haddr[31:10] == 22'h00_0000);
wire w_en = ph_wr_ff & ph_hit_ff;
wire wr_ctrl = w_en & (ph_idx_ff == `DMC_IDX_CTRL);
wire wr_cmd = w_en & (ph_idx_ff == `DMC_IDX_CMD);
wire cmd_halt = (wr_cmd & hwdata[`DMC_C_HALT]) | halt_evt_in;
wire cmd_resume = wr_cmd & hwdata[`DMC_C_RESUME];
wire cmd_trig = (wr_cmd & hwdata[`DMC_C_TRIG]) | trig_in;
wire [2:0] flag_clr = (w_en & (ph_idx_ff == `DMC_IDX_FLAGS)) ? hwdata[2:0] : 3'h0;
wire [1:0] act = ctrl_ff[`DMC_F_ACT_LO+1:`DMC_F_ACT_LO];
wire [1:0] evo = ctrl_ff[`DMC_F_EVO_LO+1:`DMC_F_EVO_LO];
wire [31:0] base_slot = desc_base_ff + SLOT_OFS;
wire [31:0] wb_slot = wb_base_ff + SLOT_OFS;

// ----------------------------------------
// Submodules
// ----------------------------------------
dmc_flag_reg #(
	.W(3)
) u_flags (
	.hclk(hclk),
	.hresetn(hresetn),
	.set({ev_halt_ff, ev_done_ff, ev_err_ff}),
	.clr(flag_clr),
	.q_ff(flags)
);

dmc_addr_gen u_addr (
	.ctrl(ctrl_ff),
	.cnt(cnt_ff),
	.src_end(src_end_ff),
	.dst_end(dst_end_ff),
	.src_stride(src_stride),
	.dst_stride(dst_stride),
	.src_first(src_first),
	.dst_first(dst_first)
);

// ----------------------------------------
// Register read mux
// ----------------------------------------
// Unmapped and reserved bits read as zero
always @* begin
	nxt_rdata = 32'h0000_0000;
	case (haddr[9:2])
		`DMC_IDX_DESC_BASE: nxt_rdata = desc_base_ff;
		`DMC_IDX_WB_BASE: nxt_rdata = wb_base_ff;
		`DMC_IDX_CTRL: nxt_rdata = {31'h0, enable_ff};
		`DMC_IDX_COUNT: nxt_rdata = {16'h0000, cnt_ff};
		`DMC_IDX_IEN_CLR: nxt_rdata = {29'h0, ien_ff};
		`DMC_IDX_IEN_SET: nxt_rdata = {29'h0, ien_ff};
		`DMC_IDX_FLAGS: nxt_rdata = {29'h0, flags};
		`DMC_IDX_STATE: nxt_rdata = {29'h0, fault_ff, busy_ff, wait_ff};
		default: nxt_rdata = 32'h0000_0000;
	endcase
	if (!ap_hit) begin
		nxt_rdata = 32'h0000_0000;
	end
end

// ----------------------------------------
// AHB-Lite slave and software registers
// ----------------------------------------
// Zero wait states: read data is registered at the address phase
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		hrdata <= 32'h0000_0000;
		ph_wr_ff <= 1'b0;
		ph_hit_ff <= 1'b0;
		ph_idx_ff <= 8'h00;
		desc_base_ff <= 32'h0000_0000;
		wb_base_ff <= 32'h0000_0000;
		ien_ff <= 3'h0;
	end else begin
		ph_wr_ff <= ap_take & hwrite;
		ph_hit_ff <= ap_take & ap_hit;
		ph_idx_ff <= haddr[9:2];
		if (ap_take && !hwrite) begin
			hrdata <= nxt_rdata;
		end
		if (w_en && ph_idx_ff == `DMC_IDX_DESC_BASE) begin
			desc_base_ff <= hwdata;
		end
		if (w_en && ph_idx_ff == `DMC_IDX_WB_BASE) begin
			wb_base_ff <= hwdata;
		end
		if (w_en && ph_idx_ff == `DMC_IDX_IEN_CLR) begin
			ien_ff <= ien_ff & ~hwdata[2:0];
		end
		if (w_en && ph_idx_ff == `DMC_IDX_IEN_SET) begin
			ien_ff <= ien_ff | hwdata[2:0];
		end
	end
end

// ----------------------------------------
// Interrupt request
// ----------------------------------------
// Registered, so it trails the flag by one cycle
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		irq <= 1'b0;
	end else begin
		irq <= |(flags & ien_ff);
	end
end

// ----------------------------------------
// Channel sequencer
// ----------------------------------------
// Later assignments win: hardware clears first, new events after
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		state_ff <= S_IDLE;
		widx_ff <= 2'h0;
		enable_ff <= 1'b0;
		fault_ff <= 1'b0;
		busy_ff <= 1'b0;
		wait_ff <= 1'b0;
		halted_ff <= 1'b0;
		halt_req_ff <= 1'b0;
		blk_active_ff <= 1'b0;
		wb_clrv_ff <= 1'b0;
		fetch_addr_ff <= 32'h0000_0000;
		ctrl_ff <= 16'h0000;
		cnt_ff <= 16'h0000;
		src_end_ff <= 32'h0000_0000;
		dst_end_ff <= 32'h0000_0000;
		link_ff <= 32'h0000_0000;
		src_ff <= 32'h0000_0000;
		dst_ff <= 32'h0000_0000;
		data_ff <= 32'h0000_0000;
		ev_err_ff <= 1'b0;
		ev_done_ff <= 1'b0;
		ev_halt_ff <= 1'b0;
		evt_out <= 1'b0;
		mem_req <= 1'b0;
		mem_addr <= 32'h0000_0000;
		mem_write <= 1'b0;
		mem_size <= 2'h0;
		mem_wdata <= 32'h0000_0000;
	end else begin
		ev_err_ff <= 1'b0;
		ev_done_ff <= 1'b0;
		ev_halt_ff <= 1'b0;
		evt_out <= 1'b0;
		if (cmd_halt && enable_ff) begin
			halt_req_ff <= 1'b1;
		end
		// Resume releases a halt; after a fault refetch from write-back
		if (cmd_resume && halted_ff) begin
			halted_ff <= 1'b0;
			fault_ff <= 1'b0;
			if (fault_ff) begin
				fetch_addr_ff <= wb_slot;
			end
		end
		if (!enable_ff) begin
			wait_ff <= 1'b0;
			busy_ff <= 1'b0;
		end
		case (state_ff)
			S_IDLE: begin
				if (enable_ff && halt_req_ff && !halted_ff) begin
					halted_ff <= 1'b1;
					ev_halt_ff <= 1'b1;
					halt_req_ff <= 1'b0;
				end else if (enable_ff && !halted_ff && blk_active_ff) begin
					state_ff <= S_RD;
					mem_req <= 1'b1;
					mem_addr <= src_ff;
					mem_write <= 1'b0;
				end else if (enable_ff && !halted_ff && wait_ff) begin
					state_ff <= S_FETCH;
					widx_ff <= 2'h0;
					mem_req <= 1'b1;
					mem_addr <= fetch_addr_ff + `DMC_DOFS_CTRL;
					mem_write <= 1'b0;
					mem_size <= `DMC_SIZE_WORD;
				end
			end
			S_FETCH: begin
				if (mem_ack && mem_err) begin
					mem_req <= 1'b0;
					ev_err_ff <= 1'b1;
					wait_ff <= 1'b0;
					enable_ff <= 1'b0;
					state_ff <= S_IDLE;
				end else if (mem_ack) begin
					widx_ff <= widx_ff + 2'h1;
					mem_addr <= mem_addr + 32'h0000_0004;
					case (widx_ff)
						2'h0: begin
							ctrl_ff <= mem_rdata[15:0];
							cnt_ff <= mem_rdata[31:16];
							if (!mem_rdata[`DMC_F_VALID]) begin
								mem_req <= 1'b0;
								fault_ff <= 1'b1;
								halted_ff <= 1'b1;
								ev_halt_ff <= 1'b1;
								ev_err_ff <= 1'b1;
								wait_ff <= 1'b0;
								state_ff <= S_IDLE;
							end
						end
						2'h1: src_end_ff <= mem_rdata;
						2'h2: dst_end_ff <= mem_rdata;
						default: begin
							link_ff <= mem_rdata;
							mem_req <= 1'b0;
							state_ff <= S_CALC;
						end
					endcase
				end
			end
			S_CALC: begin
				src_ff <= src_first;
				dst_ff <= dst_first;
				busy_ff <= 1'b1;
				wait_ff <= 1'b0;
				blk_active_ff <= 1'b1;
				if (cnt_ff == 16'h0000) begin
					state_ff <= S_END;
				end else begin
					state_ff <= S_RD;
					mem_req <= 1'b1;
					mem_addr <= src_first;
					mem_write <= 1'b0;
					mem_size <= ctrl_ff[`DMC_F_BEAT_LO+1:`DMC_F_BEAT_LO];
				end
			end
			S_RD: begin
				mem_size <= ctrl_ff[`DMC_F_BEAT_LO+1:`DMC_F_BEAT_LO];
				if (mem_ack && mem_err) begin
					mem_req <= 1'b0;
					ev_err_ff <= 1'b1;
					busy_ff <= 1'b0;
					wait_ff <= 1'b0;
					blk_active_ff <= 1'b0;
					enable_ff <= 1'b0;
					wb_clrv_ff <= 1'b1;
					state_ff <= S_WBI;
				end else if (mem_ack) begin
					data_ff <= mem_rdata;
					mem_addr <= dst_ff;
					mem_write <= 1'b1;
					mem_wdata <= mem_rdata;
					state_ff <= S_WR;
				end
			end
			S_WR: begin
				if (mem_ack && mem_err) begin
					mem_req <= 1'b0;
					ev_err_ff <= 1'b1;
					busy_ff <= 1'b0;
					wait_ff <= 1'b0;
					blk_active_ff <= 1'b0;
					enable_ff <= 1'b0;
					wb_clrv_ff <= 1'b1;
					state_ff <= S_WBI;
				end else if (mem_ack) begin
					cnt_ff <= cnt_ff - 16'h0001;
					src_ff <= src_ff + src_stride;
					dst_ff <= dst_ff + dst_stride;
					mem_write <= 1'b0;
					mem_addr <= src_ff + src_stride;
					evt_out <= (evo == `DMC_EVO_BEAT);
					if (cnt_ff == 16'h0001) begin
						mem_req <= 1'b0;
						state_ff <= S_END;
					end else if (!enable_ff) begin
						// Software abort at a beat boundary
						mem_req <= 1'b0;
						blk_active_ff <= 1'b0;
						wb_clrv_ff <= 1'b1;
						state_ff <= S_WBI;
					end else if (halt_req_ff) begin
						mem_req <= 1'b0;
						halted_ff <= 1'b1;
						ev_halt_ff <= 1'b1;
						halt_req_ff <= 1'b0;
						wb_clrv_ff <= 1'b0;
						state_ff <= S_WBI;
					end else begin
						state_ff <= S_RD;
					end
				end
			end
			S_END: begin
				ev_done_ff <= act[0];
				if (act[1]) begin
					halted_ff <= 1'b1;
					ev_halt_ff <= 1'b1;
				end
				evt_out <= (evo == `DMC_EVO_BLOCK);
				busy_ff <= 1'b0;
				blk_active_ff <= 1'b0;
				wb_clrv_ff <= 1'b1;
				if (link_ff == 32'h0000_0000) begin
					enable_ff <= 1'b0;
				end else begin
					fetch_addr_ff <= link_ff;
				end
				state_ff <= S_WBI;
			end
			S_WBI: begin
				// Counter and control word go back to the write-back slot
				mem_req <= 1'b1;
				mem_addr <= wb_slot + `DMC_DOFS_CTRL;
				mem_write <= 1'b1;
				mem_size <= `DMC_SIZE_WORD;
				mem_wdata <= {cnt_ff, ctrl_ff[15:1], ctrl_ff[0] & ~wb_clrv_ff};
				state_ff <= S_WB;
			end
			S_WB: begin
				if (mem_ack) begin
					mem_req <= 1'b0;
					mem_write <= 1'b0;
					ev_err_ff <= mem_err;
					state_ff <= S_IDLE;
				end
			end
			default: state_ff <= S_IDLE;
		endcase
		// A new trigger is kept even on the start cycle, but one arriving during S_FETCH is lost
		if (cmd_trig && enable_ff) begin
			wait_ff <= 1'b1;
		end
		// Software enable wins over a hardware disable
		if (wr_ctrl) begin
			enable_ff <= hwdata[0];
			if (hwdata[0] && !enable_ff) begin
				fetch_addr_ff <= base_slot;
			end
		end
	end
end

endmodule
`default_nettype wire

/* File: tb/dmc_checker.sv */
// Port checker for one DMA channel: bus answers, memory handshake, events, irq.
// Assumes a bind onto dmc_channel; sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dmc_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// Memory port, event and interrupt
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic mem_write,
	input wire logic mem_ack,
	input wire logic evt_out,
	input wire logic irq
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic rd_take;
	logic [3:0] wr_hist_ff;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	// Recent memory write answers; only the end strobe of a zero-count block comes without one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_hist_ff <= 4'h0;
		else
			wr_hist_ff <= {wr_hist_ff[2:0], mem_req && mem_ack && mem_write};
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered error");
	AST_RSV_ZERO: assert property (rd_take && haddr[31:3] == 29'h27 |=> hrdata[31:3] == 29'h0)
		else $error("reserved flag or state bits read nonzero");
	AST_UNMAPPED: assert property (rd_take && haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
		else $error("unmapped read gave data");
	AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request changed before answer");
	AST_REQ_RELEASE: assert property ($fell(mem_req) |-> $past(mem_ack))
		else $error("memory request dropped unanswered");
	AST_EVT_PULSE: assert property (evt_out |=> !evt_out)
		else $error("event strobe longer than one cycle");
	AST_EVT_CAUSE: assert property (evt_out |-> wr_hist_ff != 4'h0)
		else $error("event strobe without a finished beat");
	AST_IRQ_MASK: assert property (hsel && hready && htrans[1] && hwrite
		&& haddr == 32'h0000_0130 ##1 hwdata[2:0] == 3'h7 |-> ##3 !irq)
		else $error("irq stays up with all enables cleared");
endmodule
bind dmc_channel dmc_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req),
	.mem_addr(mem_addr), .mem_write(mem_write), .mem_ack(mem_ack), .evt_out(evt_out), .irq(irq));
`default_nettype wire

/* File: tb/dmc_mem_model.sv */
// System memory partner: one answer per request, prompt or slow, optional error.
// Assumes the bench presets mem, slow and err_addr before each block.
`timescale 1ns/100ps
`default_nettype none
module dmc_mem_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Request side
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic mem_write,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_wdata,
	// Answer side
	output logic mem_ack,
	output logic mem_err,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [logic [31:0]];
	logic [66:0] log_q [$];
	logic [31:0] err_addr = 32'hFFFF_FFFF;
	logic slow = 1'b0;
	int waited = 0;
	// Unwritten places read a pattern made from the address
	function automatic logic [31:0] fill(input logic [31:0] a);
		return a ^ 32'hA5A5_5A5A;
	endfunction
	// Read data inverted each cycle outside the answer cycle, so a stale value matches only every other cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 32'h0;
			waited <= 0;
		end else if (mem_req && !mem_ack && waited >= (slow ? 3 : 0)) begin
			mem_ack <= 1'b1;
			mem_err <= (mem_addr == err_addr);
			mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : fill(mem_addr);
			if (mem_write)
				mem[mem_addr] = mem_wdata;
			log_q.push_back({mem_write, mem_size, mem_addr, mem_wdata});
			waited <= 0;
		end else begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
			waited <= waited + (mem_req ? 1 : 0);
		end
	end
endmodule
`default_nettype wire

/* File: tb/tb_dma_channel_status_and_descriptor.sv */
// Self-checking bench for one DMA channel: registers, descriptors, beats, flags.
// Assumes dmc_channel, dmc_mem_model and dmc_checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "dmc_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_dma_channel_status_and_descriptor;
	// ----------------------------------------
	// Signals, addresses and helpers
	// ----------------------------------------
	localparam int CH = 2;
	localparam logic [31:0] DBASE = 32'h0000_1000;
	localparam logic [31:0] WSLOT = 32'h0000_2000 + CH * 16;
	localparam logic [31:0] FLG = {22'h0, `DMC_IDX_FLAGS, 2'h0};
	localparam logic [31:0] STA = {22'h0, `DMC_IDX_STATE, 2'h0};
	localparam logic [31:0] IES = {22'h0, `DMC_IDX_IEN_SET, 2'h0};
	localparam logic [31:0] IEC = {22'h0, `DMC_IDX_IEN_CLR, 2'h0};
	localparam logic [31:0] CTL = {22'h0, `DMC_IDX_CTRL, 2'h0};
	localparam logic [31:0] CMD = {22'h0, `DMC_IDX_CMD, 2'h0};
	localparam logic [31:0] CNT = {22'h0, `DMC_IDX_COUNT, 2'h0};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic trig_in = 1'b0;
	logic halt_evt_in = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] seed = 32'h556B_442B;
	wire hreadyout, hresp, mem_req, mem_write, mem_ack, mem_err, evt_out, irq;
	wire [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
	wire [1:0] mem_size;
	int miscompares = 0;
	int samples_checked = 0;
	int evts = 0;
	always #2 hclk = ~hclk;
	always @(posedge hclk) evts += (evt_out === 1'b1);
	dmc_channel #(.CH_NUM(CH)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_write(mem_write), .mem_size(mem_size), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata), .trig_in(trig_in),
		.halt_evt_in(halt_evt_in), .evt_out(evt_out), .irq(irq));
	dmc_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_write(mem_write), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_err(mem_err), .mem_rdata(mem_rdata));
	// Xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Block control word from random bits; reserved codes kept out
	function automatic logic [15:0] mk(input logic [31:0] r);
		return {r[2:0], r[3], r[4], r[5], ((r[7:6] == 2'h3) ? 2'h2 : r[7:6]), 3'h0, r[9:8],
			(r[10] ? 2'h3 : {1'b0, r[11]}), 1'b1};
	endfunction
	function automatic bit wb_done();
		return i_mem.log_q.size() > 0 && i_mem.log_q[$][66] && i_mem.log_q[$][63:32] == WSLOT;
	endfunction
	// Single word transfer; waits on hready, no assumed latency
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask
	task automatic kick(input logic trig);
		@(posedge hclk);
		if (trig) trig_in <= 1'b1; else halt_evt_in <= 1'b1;
		@(posedge hclk);
		trig_in <= 1'b0;
		halt_evt_in <= 1'b0;
	endtask
	// One block of n beats; err makes the first source read fail
	task automatic blk(input logic [15:0] c, input int n, input logic err);
		logic [31:0] se, de, ss, ds, q, fx;
		logic [66:0] e;
		int k;
		se = 32'h0100_0000 + (rnd() & 32'h0000_FFFC);
		de = 32'h0200_0000 + (rnd() & 32'h0000_FFFC);
		ss = c[10] ? (32'h1 << c[9:8]) << (c[12] ? c[15:13] : 3'h0) : 32'h0;
		ds = c[11] ? (32'h1 << c[9:8]) << (c[12] ? 3'h0 : c[15:13]) : 32'h0;
		fx = err ? 32'h1 : {29'h0, c[4], c[3], 1'b0};
		i_mem.mem[DBASE + CH * 16] = {16'(n), c};
		i_mem.mem[DBASE + CH * 16 + 4] = se; // last beat address
		i_mem.mem[DBASE + CH * 16 + 8] = de;
		i_mem.mem[DBASE + CH * 16 + 12] = 32'h0; // aligned, ends the chain
		i_mem.err_addr = err ? se - (n - 1) * ss : 32'hFFFF_FFFF;
		i_mem.log_q.delete();
		evts = 0;
		wr(CTL, 32'h0);
		wr(CTL, 32'h1);
		kick(1'b1);
		if (i_mem.slow) rdc(STA, 32'h1);
		for (k = 0; k < 3000 && !wb_done(); k++) @(posedge hclk);
		`CHK(wb_done(), 1'b1)
		for (k = 0; k < 4; k++) begin
			e = i_mem.log_q.pop_front();
			`CHK({e[66], e[63:32]}, {1'b0, DBASE + CH * 16 + 4 * k})
		end
		for (k = 0; k < (err ? 1 : n); k++) begin
			e = i_mem.log_q.pop_front();
			q = e[63:32];
			`CHK(e[66:32], {1'b0, c[9:8], se - (n - 1 - k) * ss})
			if (!err) begin
				e = i_mem.log_q.pop_front();
				`CHK(e[66:32], {1'b1, c[9:8], de - (n - 1 - k) * ds})
				if (c[9:8] == 2'h2) `CHK(e[31:0], i_mem.fill(q))
			end
		end
		e = i_mem.log_q.pop_front();
		`CHK({e[66], e[63:32], e[0]}, {1'b1, WSLOT, 1'b0})
		if (!err) `CHK(e[31:16], 16'h0)
		`CHK(evts, err ? 0 : (c[2:1] == 2'h3 ? n : int'(c[2:1] == 2'h1)))
		rdc(FLG, fx);
		`CHK(irq, |fx)
		wr(FLG, 32'h0);
		rdc(FLG, fx);
		if (!c[4] && !err) rdc(STA, 32'h0);
		if (!c[4] && !err) rdc(CNT, 32'h0);
		rdc(CTL, 32'h0);
		wr(FLG, 32'h7);
		rdc(FLG, 32'h0);
		`CHK(irq, 1'b0)
		wr(CMD, 32'h2);
		wr(CTL, 32'h0);
	endtask
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		int k;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(FLG, 32'h0);
		rdc(STA, 32'h0);
		rdc(IES, 32'h0);
		wr(32'h0000_0400, 32'hFFFF_FFFF);
		rdc(32'h0000_0400, 32'h0);
		wr(IES, 32'h7);
		wr(IEC, 32'h2);
		rdc(IES, 32'h5);
		rdc(IEC, 32'h5);
		wr(IES, 32'h2);
		wr({22'h0, `DMC_IDX_DESC_BASE, 2'h0}, DBASE);
		wr({22'h0, `DMC_IDX_WB_BASE, 2'h0}, WSLOT - CH * 16);
		// Every end action, with block and beat strobes
		for (k = 0; k < 4; k++)
			blk(mk({20'h0, k == 1, k == 3, k[1:0], 2'h2, 2'h3, k[0], k[2:0]}), k + 1, 1'b0);
		// Random descriptors over prompt and slow memory
		for (k = 0; k < 16; k++) begin
			r = rnd();
			i_mem.slow = r[14];
			blk(mk(r), 1 + r[13:12], 1'b0);
		end
		i_mem.slow = 1'b1;
		blk(mk(rnd()), 3, 1'b1);
		// Invalid descriptor halts; resume clears the fault
		i_mem.mem[DBASE + CH * 16] = 32'h0001_0000;
		wr(CTL, 32'h1);
		kick(1'b1);
		r = 32'h0;
		for (k = 0; k < 100 && r[2] !== 1'b1; k++) bus(1'b0, STA, 32'h0, r);
		`CHK(r[2], 1'b1)
		rdc(FLG, 32'h5);
		wr(CTL, 32'h0);
		wr(FLG, 32'h7);
		wr(CMD, 32'h2);
		rdc(STA, 32'h0);
		// Suspend by event and by command
		wr(CTL, 32'h1);
		kick(1'b0);
		// Halt flag lands two edges after the request
		repeat (3) @(posedge hclk);
		rdc(FLG, 32'h4);
		`CHK(irq, 1'b1)
		wr(FLG, 32'h7);
		wr(CMD, 32'h2);
		wr(CMD, 32'h1);
		repeat (3) @(posedge hclk);
		rdc(FLG, 32'h4);
		wr(IEC, 32'h7);
		rdc(IES, 32'h0);
		`CHK(irq, 1'b0)
		end_sim();
	end
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule
`default_nettype wire
